/* File: nfc_defs.svh */
/*
  nfc_defs.svh: offsets, field positions, reset values, command codes
  and timing counts for the flash command-port controller.
  Assumes a 200 MHz core clock and a 32-bit classic Wishbone bus.
*/
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

// word index of each register, byte address is four times the index
`define NFC_ADR_W         3
`define NFC_IDX_DATA      3'h0
`define NFC_IDX_CMD       3'h1
`define NFC_IDX_CTRL      3'h2
`define NFC_IDX_STAT      3'h3

// control register fields
`define NFC_CTRL_ALE      0
`define NFC_CTRL_SPARE    1
`define NFC_CTRL_WP       2
`define NFC_CTRL_CE       3
`define NFC_CTRL_RST      4'h4

// status register fields
`define NFC_STAT_READY    0
`define NFC_STAT_ACTIVE   1
`define NFC_STAT_ERUN     2
`define NFC_STAT_ESUSP    3
`define NFC_STAT_LCMD_LO  8

// command codes
`define NFC_CMD_READ_A    8'h00
`define NFC_CMD_READ_B    8'h01
`define NFC_CMD_GAPLESS   8'h02
`define NFC_CMD_SPARE     8'h50
`define NFC_CMD_READ_ID   8'h90
`define NFC_CMD_STATUS    8'h70
`define NFC_CMD_INPUT     8'h80
`define NFC_CMD_PROGRAM   8'h10
`define NFC_CMD_ERASE     8'h60
`define NFC_CMD_CONFIRM   8'hD0
`define NFC_CMD_SUSPEND   8'hB0
`define NFC_CMD_RESET     8'hFF

// array organisation of the attached memory
`define NFC_BLOCKS        1024
`define NFC_PAGES_PER_BLK 16
`define NFC_MAIN_BYTES    512
`define NFC_SPARE_BYTES   16
`define NFC_SPARE_FIRST   512
`define NFC_SPARE_LAST    527

// timing: each pin phase (setup, strobe, hold) lasts at least this long
`define NFC_CLK_NS        5
`define NFC_T_STEP_NS     25
`define NFC_STEP_CYC      ((`NFC_T_STEP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_DIV_W         3
`define NFC_SYNC_W        9

`endif

/* File: nfc_pkg.sv */
/*
  nfc_pkg: types shared by the controller and its synchroniser.
  Assumes nfc_defs.svh is on the include path.
*/
`include "nfc_defs.svh"

package nfc_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} nfc_state_e;

   typedef struct packed {
      logic [`NFC_SYNC_W-1:0] s1;
      logic [`NFC_SYNC_W-1:0] s2;
   } nfc_sync_s;

   typedef struct packed {
      nfc_state_e             state;
      logic [`NFC_DIV_W-1:0]  div;
      logic [7:0]             io_out;
      logic [31:0]            rd_data;
      logic                   ack;
      logic                   is_rd;
      logic                   is_cmd;
      logic                   ale;
      logic                   spare;
      logic                   wp;
      logic                   ce;
      logic                   erase_setup;
      logic                   erase_run;
      logic                   erase_susp;
      logic                   seen_busy;
      logic [7:0]             last_cmd;
      logic                   we_n;
      logic                   re_n;
      logic                   cle;
      logic                   ce_n;
      logic                   oe;
   } nfc_state_s;

endpackage : nfc_pkg

/* File: nfc_sync2.sv */
/*
  nfc_sync2: two-flop synchroniser for the flash data bus and ready pin.
  Assumes the inputs are asynchronous to i_core_clk.
*/
`timescale 1ns/10ps

module nfc_sync2
   import nfc_pkg::*;
(
   input  wire logic                   i_core_clk, // core clock
   input  wire logic                   i_reset,    // async reset, high
   input  wire logic [`NFC_SYNC_W-1:0] i_async,    // raw pin levels
   output logic      [`NFC_SYNC_W-1:0] o_sync      // synchronised levels
);

   nfc_sync_s q;
   nfc_sync_s d;

   // first stage feeds only the second stage
   always_comb
   begin
      d.s1 = i_async;
      d.s2 = q.s1;
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
         q <= '0;
      else
         q <= d;
   end

   assign o_sync = q.s2;

endmodule : nfc_sync2

/* File: nfc_ctrl.sv */
/*
  nfc_ctrl: Wishbone-driven controller for a NAND flash command port.
  Assumes a classic Wishbone master, one 200 MHz clock, and an external
  pad that resolves the flash bus from o_io_out and o_io_oe.
*/
// The register addresses and register access over Wishbone were chosen for this implementation.
// What this block does
// - one shared 8-bit bus carries commands, addresses and data both ways
// - host keeps address latch high through a whole address sequence
// - host pulls chip select low before the write strobe falls
// - program is 80h plus data, then 10h; memory then busy
// - erase is 60h, two block address bytes, then D0h
`timescale 1ns/10ps

module nfc_ctrl
   import nfc_pkg::*;
(
   input  wire logic        i_core_clk,             // core clock, 200 MHz
   input  wire logic        i_reset,                // async reset, high
   input  wire logic        i_wb_cyc,               // wishbone cycle
   input  wire logic        i_wb_stb,               // wishbone strobe
   input  wire logic        i_wb_we,                // wishbone write
   input  wire logic [4:0]  i_wb_adr,               // byte address
   input  wire logic [3:0]  i_wb_sel,               // byte selects
   input  wire logic [31:0] i_wb_dat,               // write data
   output logic      [31:0] o_wb_dat,               // read data
   output logic             o_wb_ack,               // acknowledge
   input  wire logic [7:0]  i_io_in,                // flash bus level
   output logic      [7:0]  o_io_out,               // flash bus drive
   output logic             o_io_oe,                // flash bus enable
   output logic             o_cle,                  // command latch
   output logic             o_ale,                  // address latch
   output logic             o_ce_n,                 // chip select
   output logic             o_we_n,                 // write strobe
   output logic             o_read_strobe_n,        // read strobe
   output logic             o_wp_n,                 // write protect
   output logic             o_spare_area_select_n,  // spare area select
   input  wire logic        i_ready_busy_n          // flash ready pin
);

   localparam logic [`NFC_DIV_W-1:0] STEP_LAST = `NFC_DIV_W'(`NFC_STEP_CYC - 1);
   localparam logic [3:0]            CTRL_RST  = `NFC_CTRL_RST;

   nfc_state_s             q;
   nfc_state_s             d;
   logic [`NFC_SYNC_W-1:0] pin_sync;
   logic                   ready;
   logic [7:0]             io_sync;
   logic                   req;
   logic                   tick;
   logic                   start;

   // word decode, used by every register branch
   function automatic logic nfc_hit(input logic [4:0] adr, input logic [`NFC_ADR_W-1:0] idx);
      nfc_hit = (adr[4:2] == idx);
   endfunction : nfc_hit

   // pins from the far side are asynchronous
   nfc_sync2 u_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    ({i_ready_busy_n, i_io_in}),
      .o_sync     (pin_sync)
   );

   assign ready   = pin_sync[`NFC_SYNC_W-1];
   assign io_sync = pin_sync[7:0];
   assign req     = i_wb_cyc & i_wb_stb & ~q.ack;
   assign tick    = (q.div == STEP_LAST);
   assign start   = req & i_wb_sel[0] & (nfc_hit(i_wb_adr, `NFC_IDX_DATA) |
                    (nfc_hit(i_wb_adr, `NFC_IDX_CMD) & i_wb_we));

   // next state: bus decode, pin phase sequencer, erase tracking
   always_comb
   begin
      d     = q;
      d.ack = 1'b0;
      d.div = tick ? '0 : q.div + `NFC_DIV_W'(1);
      // erase ends once busy then ready; decoded first so a new code wins
      if (q.erase_run & ~ready)
         d.seen_busy = 1'b1;
      if (q.erase_run & q.seen_busy & ready)
      begin
         d.erase_run = 1'b0;
         d.seen_busy = 1'b0;
      end
      unique case (q.state)
         ST_IDLE:
         begin
            if (start)
            begin
               // data port moves a byte, command port moves a command
               d.state   = ST_SETUP;
               d.div     = '0;
               d.is_rd   = ~i_wb_we;
               d.is_cmd  = nfc_hit(i_wb_adr, `NFC_IDX_CMD);
               d.io_out  = i_wb_dat[7:0];
               d.rd_data = '0;
               if (d.is_cmd)
               begin
                  d.last_cmd = i_wb_dat[7:0];
                  // erase bookkeeping so software can see suspend state
                  unique case (i_wb_dat[7:0])
                     `NFC_CMD_ERASE:   d.erase_setup = 1'b1;
                     `NFC_CMD_CONFIRM:
                     begin
                        if (q.erase_setup | q.erase_susp)
                        begin
                           d.erase_run  = 1'b1;
                           d.erase_susp = 1'b0;
                           d.seen_busy  = 1'b0;
                        end
                        d.erase_setup = 1'b0;
                     end
                     `NFC_CMD_SUSPEND:
                     begin
                        if (q.erase_run)  // only meaningful mid-erase
                        begin
                           d.erase_run  = 1'b0;
                           d.erase_susp = 1'b1;
                        end
                     end
                     `NFC_CMD_RESET:
                     begin
                        d.erase_setup = 1'b0;
                        d.erase_run   = 1'b0;
                        d.erase_susp  = 1'b0;
                     end
                     default: ;
                  endcase
               end
            end
            else if (req)
            begin
               // register access answers at once, unmapped reads zero
               d.ack     = 1'b1;
               d.rd_data = '0;
               if (nfc_hit(i_wb_adr, `NFC_IDX_CTRL))
               begin
                  d.rd_data[3:0] = {q.ce, q.wp, q.spare, q.ale};
                  if (i_wb_we & i_wb_sel[0])
                  begin
                     d.ale   = i_wb_dat[`NFC_CTRL_ALE];  // held until cleared
                     d.spare = i_wb_dat[`NFC_CTRL_SPARE];
                     d.wp    = i_wb_dat[`NFC_CTRL_WP];
                     d.ce    = i_wb_dat[`NFC_CTRL_CE];
                  end
               end
               else if (nfc_hit(i_wb_adr, `NFC_IDX_STAT))
               begin
                  d.rd_data[`NFC_STAT_READY]                 = ready;
                  d.rd_data[`NFC_STAT_ACTIVE]                = 1'b0;
                  d.rd_data[`NFC_STAT_ERUN]                  = q.erase_run;
                  d.rd_data[`NFC_STAT_ESUSP]                 = q.erase_susp;
                  d.rd_data[`NFC_STAT_LCMD_LO+7:`NFC_STAT_LCMD_LO] = q.last_cmd;
               end
            end
         end
         ST_SETUP:
         begin
            if (tick)
               d.state = ST_STROBE;
         end
         ST_STROBE:
         begin
            if (tick)
            begin
               d.state = ST_HOLD;
               // byte sampled late in the read strobe, after two sync flops
               if (q.is_rd)
                  d.rd_data = {24'h0, io_sync};
            end
         end
         ST_HOLD:
         begin
            if (tick)
            begin
               d.state = ST_IDLE;
               d.ack   = 1'b1;
            end
         end
      endcase
      // pins registered from the next state so they never glitch
      d.we_n = ~((d.state == ST_STROBE) & ~d.is_rd);
      d.re_n = ~((d.state == ST_STROBE) & d.is_rd);
      d.cle  = (d.state != ST_IDLE) & d.is_cmd;
      d.ce_n = ~(d.ce | (d.state != ST_IDLE));
      d.oe   = (d.state != ST_IDLE) & ~d.is_rd;
   end

   // single state register; write protect asserted out of reset for safety
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         q          <= '0;
         q.state    <= ST_IDLE;
         q.wp       <= CTRL_RST[`NFC_CTRL_WP];
         q.we_n     <= 1'b1;
         q.re_n     <= 1'b1;
         q.ce_n     <= 1'b1;
      end
      else
         q <= d;
   end

   assign o_wb_dat              = q.rd_data;
   assign o_wb_ack              = q.ack;
   assign o_io_out              = q.io_out;
   assign o_io_oe               = q.oe;
   assign o_cle                 = q.cle;
   assign o_ale                 = q.ale & ~q.cle;   // never both latches
   assign o_ce_n                = q.ce_n;
   assign o_we_n                = q.we_n;
   assign o_read_strobe_n       = q.re_n;
   assign o_wp_n                = ~q.wp;
   assign o_spare_area_select_n = ~q.spare;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   a_strobe_excl: assert property (!(!o_we_n && !o_read_strobe_n))
      else $error("read and write strobes low together");
   a_latch_excl: assert property (!(o_cle && o_ale))
      else $error("both latch strobes high");
   a_ce_first: assert property ($fell(o_we_n) |-> !o_ce_n && !$past(o_ce_n))
      else $error("chip select not low before write strobe fell");
   a_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*5] ##1 o_we_n)
      else $error("write strobe width wrong");
   a_bus_drive: assert property (!o_read_strobe_n |-> !o_io_oe)
      else $error("bus driven during read strobe");
   a_data_stable: assert property (!o_we_n |=> $stable(o_io_out) || o_we_n)
      else $error("bus data moved under write strobe");
   a_ale_hold: assert property ((!o_we_n && o_ale) |=> o_ale)
      else $error("address latch dropped mid strobe");
   a_erase_start: assert property ($rose(q.erase_run) |-> $past(q.last_cmd) == `NFC_CMD_CONFIRM
                                   || q.last_cmd == `NFC_CMD_CONFIRM)
      else $error("erase flagged without confirm code");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("acknowledge longer than one cycle");

endmodule : nfc_ctrl

/* File: nfc_flash_model.sv */
/*
  nfc_flash_model: behavioural one-page flash memory behind the pins.
  Assumes the bench resolves the shared bus from both drivers.
*/
`timescale 1ns/10ps

module nfc_flash_model
#(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_ID   = 8'hC3, // arbitrary value
   parameter int         BUSY_T   = 80     // busy time in 10 ns ticks
)
(
   input  wire logic       i_cle,                 // command latch
   input  wire logic       i_ale,                 // address latch
   input  wire logic       i_ce_n,                // chip select
   input  wire logic       i_we_n,                // write strobe
   input  wire logic       i_read_strobe_n,       // read strobe
   input  wire logic       i_wp_n,                // write protect
   input  wire logic       i_spare_area_select_n, // spare select
   input  wire logic [7:0] i_io,                  // resolved bus
   output logic      [7:0] o_io,                  // model drive
   output logic            o_ready_busy_n,        // ready pin
   output int              o_viol                 // pin misuse count
);
   logic [7:0] mem  [0:527]; // one page, 512 main plus 16 spare
   logic [7:0] dreg [0:527];
   logic [7:0] cmd_q;
   logic       ale_f, armed, ers, susp, fail;
   int         col_q, nadr, left;

   // column pattern so every read start point shows
   initial
   begin
      for (int i = 0; i < 528; i++)
         mem[i] = 8'(i ^ (i >> 4));
      {cmd_q, ale_f, armed, ers, susp, fail} = '0;
      col_q = 0;
      nadr = 0;
      left = 0;
      o_viol = 0;
      o_io = 8'h00;
   end

   // suspend freezes the timer and frees the pin
   always #10 if (left > 0 && !susp) left--;
   assign o_ready_busy_n = (left == 0) || susp;

   task automatic command(input logic [7:0] c);
      nadr = 0;
      col_q = 0;
      if (c inside {8'h00, 8'h01, 8'h02, 8'h50, 8'h70, 8'h90}) cmd_q = c;
      case (c)
         8'h80: dreg = mem;
         8'h10:
            if (i_wp_n)
            begin
               mem = dreg;
               left = BUSY_T;
               ers = 1'b0;
            end
            else
               fail = 1'b1;
         8'h60: armed = 1'b1;
         8'hD0: if (!i_wp_n) fail = 1'b1;
            else if (susp) susp = 1'b0;
            else if (armed) {left, ers, armed} = {BUSY_T, 2'b10};
         8'hB0: if (ers && left > 0) susp = 1'b1;
         8'hFF: {left, ers, armed, susp, fail} = '0;
         default: ;
      endcase
   endtask : command

   // misuse checks at the strobe fall
   always @(negedge i_we_n)
   begin
      if (i_ce_n || !i_read_strobe_n || (i_cle && i_ale)) o_viol++;
      ale_f = i_ale;
   end

   // latching on the strobe rise, ignored in standby
   always @(posedge i_we_n)
      if (!i_ce_n)
      begin
         if (i_ale !== ale_f) o_viol++;
         if (i_cle) command(i_io);
         else if (i_ale) {col_q, nadr} = {(nadr == 0) ? 32'(i_io) : col_q, nadr + 1};
         else {dreg[col_q], col_q} = {i_io, col_q + 1};
      end

   // each read strobe fall puts out the next byte
   always @(negedge i_read_strobe_n)
      if (!i_ce_n)
      begin
         if (!i_we_n) o_viol++;
         case (cmd_q)
            8'h90: o_io = col_q[0] ? DEV_ID : MAKER_ID;
            8'h70: o_io = {i_wp_n, o_ready_busy_n, susp, 4'h0, fail};
            8'h50: o_io = i_spare_area_select_n ? 8'hFF : mem[512 + col_q];
            8'h01: o_io = mem[256 + col_q];
            default: o_io = mem[col_q];
         endcase
         col_q++;
      end

   // released bus shows the inverse, never a stale byte
   always @(posedge i_read_strobe_n) o_io = ~o_io;
endmodule : nfc_flash_model

/* File: nand_flash_command_interface_bench.sv */
/*
  bench for nfc_ctrl: wishbone task calls against a flash model.
  Assumes the design files and nfc_flash_model.sv compile first.
*/
`timescale 1ns/10ps

module nand_flash_command_interface_bench;
   logic        clk, rst, cyc, stb, we, ack, ioe, cle, ale;
   logic        ce_n, we_n, re_n, wp_n, se_n, rb_n;
   logic [4:0]  adr;
   logic [7:0]  io_out, mdl_io;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  codes [5] = '{8'h00, 8'h01, 8'h50, 8'h50, 8'h02};
   logic [15:0] exps  [5] = '{16'hA55A, 16'h1112, 16'h2122, 16'hFFFF, 16'hA55A};
   wire  [7:0]  io = ioe ? io_out : mdl_io; // resolved shared bus
   int          err_count, samples_checked, cycles, viol;

   nfc_ctrl dut_u (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_io_in(io), .o_io_out(io_out), .o_io_oe(ioe), .o_cle(cle), .o_ale(ale), .o_ce_n(ce_n),
      .o_we_n(we_n), .o_read_strobe_n(re_n), .o_wp_n(wp_n), .o_spare_area_select_n(se_n),
      .i_ready_busy_n(rb_n));

   nfc_flash_model mdl_u (.i_cle(cle), .i_ale(ale), .i_ce_n(ce_n), .i_we_n(we_n),
      .i_read_strobe_n(re_n), .i_wp_n(wp_n), .i_spare_area_select_n(se_n), .i_io(io),
      .o_io(mdl_io), .o_ready_busy_n(rb_n), .o_viol(viol));

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // hang guard, runs far past the expected length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk

   // one classic cycle; no limit of its own, the hang guard ends a stuck run
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask : wb

   task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      wb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask : rdc

   task automatic cmd(input logic [7:0] c); wb(1'b1, 5'h04, {24'h0, c}); endtask : cmd
   task automatic wr(input logic [7:0] b); wb(1'b1, 5'h00, {24'h0, b}); endtask : wr
   task automatic ctl(input logic [3:0] v); wb(1'b1, 5'h08, {28'h0, v}); endtask : ctl

   task automatic wait_ready;
      do wb(1'b0, 5'h0C, 32'h0); while (q[0] !== 1'b1);
   endtask : wait_ready

   // two-cycle block address after an erase setup
   task automatic erase_seq(input logic [3:0] c);
      cmd(8'h60);
      ctl(c | 4'h1);
      wr(8'h00);
      wr(8'h00);
      ctl(c);
      cmd(8'hD0);
   endtask : erase_seq

   initial
   begin
      {clk, rst, cyc, stb, we, adr, wdat} = {2'b01, 3'b000, 5'h00, 32'h0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // register and pin state after reset
      rdc(5'h08, 32'h4, 32'hFFFFFFFF);
      rdc(5'h10, 32'h0, 32'hFFFFFFFF);
      rdc(5'h04, 32'h0, 32'hFFFFFFFF);
      rdc(5'h0C, 32'h1, 32'hFFFFFFFF);
      chk({wp_n, se_n, ce_n}, 3'b011);
      ctl(4'h0);
      chk(wp_n, 1'b1);
      ctl(4'h8);
      chk(ce_n, 1'b0);
      ctl(4'h0);
      $display("reset test done");
      // identifier read after one address byte
      cmd(8'h90);
      ctl(4'h1);
      wr(8'h00);
      ctl(4'h0);
      rdc(5'h00, 32'h5A, 32'hFFFFFFFF);
      rdc(5'h00, 32'hC3, 32'hFFFFFFFF);
      rdc(5'h0C, 32'h9000, 32'hFF00);
      $display("id test done");
      // two-step program of columns 1 and 2
      cmd(8'h80);
      ctl(4'h1);
      wr(8'h01);
      wr(8'h00);
      ctl(4'h0);
      wr(8'hA5);
      wr(8'h5A);
      cmd(8'h10);
      rdc(5'h0C, 32'h0, 32'h1);
      wait_ready();
      cmd(8'h70);
      rdc(5'h00, 32'hC0, 32'hFF);
      $display("program test done");
      // every read mode from column 1, spare with and without select
      for (int k = 0; k < 5; k++)
      begin
         ctl({2'b00, k == 2, 1'b0});
         cmd(codes[k]);
         ctl({2'b00, k == 2, 1'b1});
         wr(8'h01);
         ctl({2'b00, k == 2, 1'b0});
         rdc(5'h00, {24'h0, exps[k][15:8]}, 32'hFFFFFFFF);
         rdc(5'h00, {24'h0, exps[k][7:0]}, 32'hFFFFFFFF);
      end
      $display("read test done");
      // erase refused while protected, then reinitialise
      erase_seq(4'h4);
      rdc(5'h0C, 32'h5, 32'hF);
      cmd(8'h70);
      rdc(5'h00, 32'h41, 32'hFF);
      cmd(8'hFF);
      rdc(5'h0C, 32'h1, 32'hF);
      $display("protect test done");
      // erase, suspend in mid-run, resume to the end
      erase_seq(4'h0);
      rdc(5'h0C, 32'h4, 32'h5);
      cmd(8'hB0);
      rdc(5'h0C, 32'h8, 32'h8);
      cmd(8'h70);
      rdc(5'h00, 32'hE0, 32'hFF);
      cmd(8'hD0);
      rdc(5'h0C, 32'h0, 32'h1);
      wait_ready();
      rdc(5'h0C, 32'h1, 32'hD);
      chk(viol, 32'h0);
      $display("erase test done");
      // mid-run reset puts protection back on
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(5'h08, 32'h4, 32'hFFFFFFFF);
      chk(wp_n, 1'b0);
      $display("second reset test done");
      stop_test();
   end
endmodule : nand_flash_command_interface_bench
